/* src/ecm_loader.sv */
// Configuration image loader with its control registers and Avalon-MM slave.
//
// The Avalon-MM interface to the registers and the register addresses are this design's own decisions.
`default_nettype none

// Operation
// R1: Each device block starts at byte 0x03 plus its slot times the block stride.
// R2: Header byte 0 bit 7 enables CRC checking, bit 6 flags address map.
// R3: Header byte 0 bit 5 flags large memory, bits 3-0 count devices.
// R4: Header byte 2 is the maximum burst length; header defaults are zero.
// R5: Image byte 0x03 loads control byte 0x01 bit for bit.
// R6: Image byte 0x04 scatters into control bytes 0x02 and 0x04.
// R7: Image bytes 0x08 and 0x09 load control bytes 0x0F and 0x10 whole.
// R8: Image byte 0x0A loads lane A emphasis cut and quiet levels.
// R9: Lane B boost byte joins nibbles from image bytes 0x0B and 0x0C.
// R10: Image byte 0x0D loads control bytes 0x17, 0x18 and 0x19 bit 7.
// R11: Image byte 0x0B upper nibble loads control byte 0x15 bits 5-2.
// R12: CRC-8 covers header and 37 data bytes, checked against the following byte.
// R13: Fetch starts once the chain permit is low; done output then drops low.
module ecm_loader
   import ecm_pkg::*;
(
   input wire logic core_clk_in,
   input wire logic rst_b_in,
   input wire logic [8:0] avs_address_in,
   input wire logic avs_read_in,
   input wire logic avs_write_in,
   input wire logic [31:0] avs_writedata_in,
   input wire logic [3:0] avs_byteenable_in,
   output logic [31:0] avs_readdata_out,
   output logic avs_waitrequest_out,
   input wire logic chain_load_permit_in,
   output logic load_done_b_out,
   output logic fetch_req_out,
   output logic [9:0] fetch_addr_out,
   input wire logic fetch_valid_in,
   input wire logic [7:0] fetch_data_in,
   output ecm_cfg_t cfg_out,
   output ecm_hdr_t hdr_out
);
   logic permit_meta_ff;
   logic permit_sync_ff;
   ecm_state_t state_ff;
   ecm_state_t nxt_state;
   logic [5:0] idx_ff;
   logic [5:0] nxt_idx;
   logic req_ff;
   logic nxt_req;
   logic [9:0] addr_ff;
   logic [9:0] nxt_addr;
   logic done_b_ff;
   logic nxt_done_b;
   logic crc_err_ff;
   logic nxt_crc_err;
   logic crc_chk_ff;
   logic nxt_crc_chk;
   logic crc_clear;
   logic [7:0] crc_val;
   ecm_cfg_t cfg_ff;
   ecm_cfg_t nxt_cfg;
   ecm_hdr_t hdr_ff;
   ecm_hdr_t nxt_hdr;
   logic [3:0] slot_ff;
   logic [3:0] nxt_slot;
   logic wait_ff;
   logic nxt_wait;
   logic [31:0] rdata_ff;
   logic [31:0] nxt_rdata;
   logic bus_req;
   logic sw_wr;
   logic restart;
   logic byte_take;
   logic [6:0] reg_index;
   logic [CTL_COUNT-1:0][7:0] cfg_view;

   // Start address of the image byte at logical position k for this slot.
   function automatic logic [9:0] image_addr(input logic [5:0] k, input logic [3:0] slot);
      logic [9:0] base;
      base = FIRST_BLOCK + 10'(slot) * BLOCK_STRIDE;
      if (k < IMG_CTL_01)
         image_addr = {4'h0, k};
      else
         image_addr = base + {4'h0, k} - FIRST_BLOCK;
   endfunction

   // Chain permit pin passes two flip-flops.
   always_ff @(posedge core_clk_in or negedge rst_b_in)
   begin
      if (!rst_b_in)
      begin
         permit_meta_ff <= 1'b1;
         permit_sync_ff <= 1'b1;
      end
      else
      begin
         permit_meta_ff <= chain_load_permit_in;
         permit_sync_ff <= permit_meta_ff;
      end
   end

   assign bus_req = avs_read_in | avs_write_in;
   assign sw_wr = avs_write_in & ~wait_ff;
   assign reg_index = avs_address_in[8:2];
   assign restart = sw_wr & avs_byteenable_in[1] & (reg_index == REG_CONTROL)
      & avs_writedata_in[CTRL_RESTART];
   assign byte_take = fetch_valid_in & (state_ff == ECM_FETCH);
   assign cfg_view = cfg_ff;

   // Loader sequence.
   always_comb
   begin
      nxt_state = state_ff;
      nxt_idx = idx_ff;
      nxt_req = req_ff;
      nxt_addr = addr_ff;
      nxt_done_b = done_b_ff;
      nxt_crc_err = crc_err_ff;
      nxt_crc_chk = crc_chk_ff;
      crc_clear = 1'b0;
      case (state_ff)
         ECM_WAIT:
         begin
            // R13: waits for permit
            if (!permit_sync_ff)
            begin
               nxt_state = ECM_FETCH;
               nxt_idx = IMG_FLAGS;
               nxt_req = 1'b1;
               nxt_addr = image_addr(IMG_FLAGS, slot_ff);
               nxt_crc_err = 1'b0;
               nxt_crc_chk = 1'b0;
               crc_clear = 1'b1;
            end
         end
         ECM_FETCH:
         begin
            if (fetch_valid_in)
            begin
               if (idx_ff == IMG_CRC)
               begin
                  // R12: compares stored check byte
                  nxt_state = ECM_DONE;
                  nxt_req = 1'b0;
                  nxt_crc_chk = hdr_ff.crc_en;
                  nxt_crc_err = hdr_ff.crc_en & (fetch_data_in != crc_val);
                  // R13: signals load complete
                  nxt_done_b = 1'b0;
               end
               else
               begin
                  nxt_idx = idx_ff + 6'h01;
                  // R1: aligns device blocks
                  nxt_addr = image_addr(idx_ff + 6'h01, slot_ff);
               end
            end
         end
         ECM_DONE:
         begin
            if (restart)
            begin
               nxt_state = ECM_WAIT;
               nxt_done_b = 1'b1;
            end
         end
         default:
         begin
            nxt_state = ECM_WAIT;
            nxt_req = 1'b0;
            nxt_done_b = 1'b1;
         end
      endcase
   end

   always_ff @(posedge core_clk_in or negedge rst_b_in)
   begin
      if (!rst_b_in)
      begin
         state_ff <= ECM_WAIT;
         idx_ff <= IMG_FLAGS;
         req_ff <= 1'b0;
         addr_ff <= 10'h000;
         done_b_ff <= 1'b1;
         crc_err_ff <= 1'b0;
         crc_chk_ff <= 1'b0;
      end
      else
      begin
         state_ff <= nxt_state;
         idx_ff <= nxt_idx;
         req_ff <= nxt_req;
         addr_ff <= nxt_addr;
         done_b_ff <= nxt_done_b;
         crc_err_ff <= nxt_crc_err;
         crc_chk_ff <= nxt_crc_chk;
      end
   end

   // R12: accumulates forty bytes
   ecm_crc8 u_crc
   (
      .core_clk_in(core_clk_in),
      .rst_b_in(rst_b_in),
      .clear_in(crc_clear),
      .byte_valid_in(byte_take && (idx_ff != IMG_CRC)),
      .byte_in(fetch_data_in),
      .crc_out(crc_val)
   );

   // Header and control bytes; a loaded byte wins over a software write.
   always_comb
   begin
      logic [CTL_COUNT-1:0][7:0] sw_bytes;
      sw_bytes = cfg_ff;
      for (int i = 0; i < CTL_COUNT; i++)
      begin
         if (sw_wr && avs_byteenable_in[0] && (reg_index == CTL_INDEX[i]))
            sw_bytes[CTL_COUNT-1-i] = avs_writedata_in[7:0];
      end
      nxt_cfg = sw_bytes;
      nxt_hdr = hdr_ff;
      nxt_slot = slot_ff;
      if (sw_wr && avs_byteenable_in[0] && (reg_index == REG_CONTROL))
         nxt_slot = avs_writedata_in[3:0];
      if (byte_take)
      begin
         case (idx_ff)
            IMG_FLAGS:
            begin
               // R2: takes check and map flags
               nxt_hdr.crc_en = fetch_data_in[HDR_CRC_EN];
               nxt_hdr.map_present = fetch_data_in[HDR_MAP];
               // R3: takes size flag, count
               nxt_hdr.large_image = fetch_data_in[HDR_LARGE];
               nxt_hdr.dev_count = fetch_data_in[3:0];
            end
            IMG_BURST:
            begin
               // R4: takes burst length
               nxt_hdr.burst_max = fetch_data_in;
            end
            IMG_CTL_01:
            begin
               // R5: copies whole byte
               nxt_cfg.ctl_01 = fetch_data_in;
            end
            IMG_CTL_02:
            begin
               // R6: scatters power bits
               nxt_cfg.ctl_02[5:2] = fetch_data_in[7:4];
               nxt_cfg.ctl_02[0] = fetch_data_in[3];
               nxt_cfg.ctl_04[7:5] = fetch_data_in[2:0];
            end
            IMG_CTL_0F:
            begin
               // R7: loads lane A boost
               nxt_cfg.ctl_0f = fetch_data_in;
            end
            IMG_CTL_10:
            begin
               // R7: loads lane A driver
               nxt_cfg.ctl_10 = fetch_data_in;
            end
            IMG_CTL_11:
            begin
               // R8: loads emphasis, levels
               nxt_cfg.ctl_11[2:0] = fetch_data_in[7:5];
               nxt_cfg.ctl_12[7] = fetch_data_in[4];
               nxt_cfg.ctl_12[3:0] = fetch_data_in[3:0];
            end
            IMG_CTL_15:
            begin
               // R11: loads quiet controls
               nxt_cfg.ctl_15[5:2] = fetch_data_in[7:4];
               // R9: upper boost nibble
               nxt_cfg.ctl_16[7:4] = fetch_data_in[3:0];
            end
            IMG_CTL_16:
            begin
               // R9: lower boost nibble
               nxt_cfg.ctl_16[3:0] = fetch_data_in[7:4];
               nxt_cfg.ctl_17[7:4] = fetch_data_in[3:0];
            end
            IMG_CTL_17:
            begin
               // R10: scatters lane B bits
               nxt_cfg.ctl_17[3:0] = fetch_data_in[7:4];
               nxt_cfg.ctl_18[2:0] = fetch_data_in[3:1];
               nxt_cfg.ctl_19[7] = fetch_data_in[0];
            end
            default:
            begin
               nxt_cfg = sw_bytes;
            end
         endcase
      end
   end

   always_ff @(posedge core_clk_in or negedge rst_b_in)
   begin
      if (!rst_b_in)
      begin
         cfg_ff <= '{RST_ZERO, RST_ZERO, RST_ZERO, RST_CTL_0F, RST_CTL_10, RST_CTL_11,
            RST_ZERO, RST_ZERO, RST_CTL_16, RST_CTL_17, RST_CTL_18, RST_ZERO};
         // R4: header defaults zero
         hdr_ff <= '0;
         slot_ff <= 4'h0;
      end
      else
      begin
         cfg_ff <= nxt_cfg;
         hdr_ff <= nxt_hdr;
         slot_ff <= nxt_slot;
      end
   end

   // Bus slave answers every request after one wait cycle.
   always_comb
   begin
      logic [31:0] word;
      word = 32'h0000_0000;
      for (int i = 0; i < CTL_COUNT; i++)
      begin
         if (reg_index == CTL_INDEX[i])
            word = {24'h00_0000, cfg_view[CTL_COUNT-1-i]};
      end
      case (reg_index)
         REG_STATUS:
         begin
            word[STS_DONE] = ~done_b_ff;
            word[STS_BUSY] = (state_ff == ECM_FETCH);
            word[STS_CRC_ERR] = crc_err_ff;
            word[STS_CRC_CHECKED] = crc_chk_ff;
         end
         REG_HEADER:
         begin
            word = {16'h0000, hdr_ff.burst_max, hdr_ff.crc_en, hdr_ff.map_present,
               hdr_ff.large_image, 1'b0, hdr_ff.dev_count};
         end
         REG_CONTROL:
         begin
            word = {28'h000_0000, slot_ff};
         end
         default:
         begin
            word = word;
         end
      endcase
      nxt_wait = ~(bus_req & wait_ff);
      nxt_rdata = (avs_read_in && wait_ff) ? word : rdata_ff;
   end

   always_ff @(posedge core_clk_in or negedge rst_b_in)
   begin
      if (!rst_b_in)
      begin
         wait_ff <= 1'b1;
         rdata_ff <= 32'h0000_0000;
      end
      else
      begin
         wait_ff <= nxt_wait;
         rdata_ff <= nxt_rdata;
      end
   end

   assign avs_readdata_out = rdata_ff;
   assign avs_waitrequest_out = wait_ff;
   assign load_done_b_out = done_b_ff;
   assign fetch_req_out = req_ff;
   assign fetch_addr_out = addr_ff;
   assign cfg_out = cfg_ff;
   assign hdr_out = hdr_ff;

   default clocking cb @(posedge core_clk_in);
   endclocking
   default disable iff (!rst_b_in);

   a_fetch_after_permit: assert property ( // R13
      $rose(fetch_req_out) |-> !$past(permit_sync_ff))
      else $error("Fetch began without chain permit.");
   a_done_after_crc: assert property ( // R13
      byte_take && idx_ff == IMG_CRC |=> !load_done_b_out && !fetch_req_out ##1 !load_done_b_out)
      else $error("Done output not low after last byte.");
   a_crc_verdict: assert property ( // R12
      byte_take && idx_ff == IMG_CRC && hdr_ff.crc_en
      |=> crc_err_ff == ($past(fetch_data_in) != $past(crc_val)))
      else $error("CRC verdict wrong.");
   a_block_start: assert property ( // R1
      fetch_req_out && idx_ff == IMG_CTL_01
      |-> fetch_addr_out == FIRST_BLOCK + 10'(slot_ff) * BLOCK_STRIDE)
      else $error("Device block start address wrong.");
   a_header_flags: assert property ( // R2
      byte_take && idx_ff == IMG_FLAGS |=> hdr_out.crc_en == $past(fetch_data_in[7])
      && hdr_out.map_present == $past(fetch_data_in[6]))
      else $error("Header flags not taken.");
   a_header_count: assert property ( // R3
      byte_take && idx_ff == IMG_FLAGS |=> hdr_out.large_image == $past(fetch_data_in[5])
      && hdr_out.dev_count == $past(fetch_data_in[3:0]))
      else $error("Header count not taken.");
   a_burst_length: assert property ( // R4
      byte_take && idx_ff == IMG_BURST |=> hdr_out.burst_max == $past(fetch_data_in))
      else $error("Burst length not taken.");
   a_map_ctl01: assert property ( // R5
      byte_take && idx_ff == IMG_CTL_01 |=> cfg_out.ctl_01 == $past(fetch_data_in))
      else $error("Control byte 0x01 not loaded.");
   a_map_ctl02: assert property ( // R6
      byte_take && idx_ff == IMG_CTL_02 |=> cfg_out.ctl_02[5:2] == $past(fetch_data_in[7:4])
      && cfg_out.ctl_02[0] == $past(fetch_data_in[3])
      && cfg_out.ctl_04[7:5] == $past(fetch_data_in[2:0]))
      else $error("Control bytes 0x02 and 0x04 not loaded.");
   a_map_boost_a: assert property ( // R7
      byte_take && idx_ff == IMG_CTL_0F |=> cfg_out.ctl_0f == $past(fetch_data_in))
      else $error("Lane A boost not loaded.");
   a_map_emph_a: assert property ( // R8
      byte_take && idx_ff == IMG_CTL_11 |=> cfg_out.ctl_11[2:0] == $past(fetch_data_in[7:5])
      && cfg_out.ctl_12[3:0] == $past(fetch_data_in[3:0]))
      else $error("Lane A emphasis not loaded.");
   a_map_boost_b: assert property ( // R9
      byte_take && idx_ff == IMG_CTL_15 |=> cfg_out.ctl_16[7:4] == $past(fetch_data_in[3:0]))
      else $error("Lane B boost upper nibble not loaded.");
   a_boost_b_low: assert property ( // R9
      byte_take && idx_ff == IMG_CTL_16 |=> cfg_out.ctl_16[3:0] == $past(fetch_data_in[7:4]))
      else $error("Lane B boost lower nibble not loaded.");
   a_map_ctl17: assert property ( // R10
      byte_take && idx_ff == IMG_CTL_17 |=> cfg_out.ctl_17[3:0] == $past(fetch_data_in[7:4])
      && cfg_out.ctl_18[2:0] == $past(fetch_data_in[3:1])
      && cfg_out.ctl_19[7] == $past(fetch_data_in[0]))
      else $error("Lane B bytes not loaded.");
   a_map_ctl15: assert property ( // R11
      byte_take && idx_ff == IMG_CTL_15 |=> cfg_out.ctl_15[5:2] == $past(fetch_data_in[7:4]))
      else $error("Lane B quiet controls not loaded.");

   c_load_clean: cover property (byte_take && idx_ff == IMG_CRC ##1 !crc_err_ff);
   c_load_crc_err: cover property (byte_take && idx_ff == IMG_CRC ##1 crc_err_ff);
   c_restart: cover property (state_ff == ECM_DONE && restart ##1 state_ff == ECM_WAIT);
endmodule

`default_nettype wire

/* src/ecm_crc8.sv */
// Shared package and the CRC-8 accumulator of the configuration image loader.
`default_nettype none

package ecm_pkg;
   // Image layout.
   localparam logic [9:0] FIRST_BLOCK = 10'h003;
   localparam logic [9:0] BLOCK_STRIDE = 10'h026;
   localparam logic [5:0] IMG_FLAGS = 6'h00;
   localparam logic [5:0] IMG_BURST = 6'h02;
   localparam logic [5:0] IMG_CTL_01 = 6'h03;
   localparam logic [5:0] IMG_CTL_02 = 6'h04;
   localparam logic [5:0] IMG_CTL_0F = 6'h08;
   localparam logic [5:0] IMG_CTL_10 = 6'h09;
   localparam logic [5:0] IMG_CTL_11 = 6'h0a;
   localparam logic [5:0] IMG_CTL_15 = 6'h0b;
   localparam logic [5:0] IMG_CTL_16 = 6'h0c;
   localparam logic [5:0] IMG_CTL_17 = 6'h0d;
   localparam logic [5:0] IMG_CRC = 6'h28;
   // Header flag positions in image byte 0.
   localparam int HDR_CRC_EN = 7;
   localparam int HDR_MAP = 6;
   localparam int HDR_LARGE = 5;
   // CRC-8 with polynomial x^8 + x^2 + x + 1.
   localparam logic [7:0] CRC_POLY = 8'h07;
   localparam logic [7:0] CRC_INIT = 8'h00;
   // Register indices; the byte address is four times the index.
   localparam int CTL_COUNT = 12;
   localparam logic [6:0] CTL_INDEX [CTL_COUNT] = '{7'h01, 7'h02, 7'h04, 7'h0f, 7'h10,
      7'h11, 7'h12, 7'h15, 7'h16, 7'h17, 7'h18, 7'h19};
   localparam logic [6:0] REG_STATUS = 7'h40;
   localparam logic [6:0] REG_HEADER = 7'h41;
   localparam logic [6:0] REG_CONTROL = 7'h42;
   // Own register fields.
   localparam int STS_DONE = 0;
   localparam int STS_BUSY = 1;
   localparam int STS_CRC_ERR = 2;
   localparam int STS_CRC_CHECKED = 3;
   localparam int CTRL_RESTART = 8;
   // Control byte reset values.
   localparam logic [7:0] RST_ZERO = 8'h00;
   localparam logic [7:0] RST_CTL_0F = 8'h2f;
   localparam logic [7:0] RST_CTL_10 = 8'hed;
   localparam logic [7:0] RST_CTL_11 = 8'h02;
   localparam logic [7:0] RST_CTL_16 = 8'h2f;
   localparam logic [7:0] RST_CTL_17 = 8'hed;
   localparam logic [7:0] RST_CTL_18 = 8'h02;

   typedef struct packed {
      logic [7:0] ctl_01;
      logic [7:0] ctl_02;
      logic [7:0] ctl_04;
      logic [7:0] ctl_0f;
      logic [7:0] ctl_10;
      logic [7:0] ctl_11;
      logic [7:0] ctl_12;
      logic [7:0] ctl_15;
      logic [7:0] ctl_16;
      logic [7:0] ctl_17;
      logic [7:0] ctl_18;
      logic [7:0] ctl_19;
   } ecm_cfg_t;

   typedef struct packed {
      logic crc_en;
      logic map_present;
      logic large_image;
      logic [3:0] dev_count;
      logic [7:0] burst_max;
   } ecm_hdr_t;

   typedef enum logic [1:0] {
      ECM_WAIT = 2'b00,
      ECM_FETCH = 2'b01,
      ECM_DONE = 2'b11
   } ecm_state_t;
endpackage

module ecm_crc8
   import ecm_pkg::*;
(
   input wire logic core_clk_in,
   input wire logic rst_b_in,
   input wire logic clear_in,
   input wire logic byte_valid_in,
   input wire logic [7:0] byte_in,
   output logic [7:0] crc_out
);
   logic [7:0] crc_ff;
   logic [7:0] nxt_crc;

   // Folds one byte into the running remainder, most significant bit first.
   always_comb
   begin
      logic [7:0] acc;
      acc = crc_ff ^ byte_in;
      for (int i = 0; i < 8; i++)
      begin
         acc = acc[7] ? ((acc << 1) ^ CRC_POLY) : (acc << 1);
      end
      if (clear_in)
         nxt_crc = CRC_INIT;
      else if (byte_valid_in)
         nxt_crc = acc;
      else
         nxt_crc = crc_ff;
   end

   always_ff @(posedge core_clk_in or negedge rst_b_in)
   begin
      if (!rst_b_in)
         crc_ff <= CRC_INIT;
      else
         crc_ff <= nxt_crc;
   end

   assign crc_out = crc_ff;
endmodule

`default_nettype wire

/* src/ecm_loader_fix.sv */
// Intentionally empty companion kept out of the build.
`default_nettype none
`default_nettype wire

/* tb/ecm_mem_model.sv */
// Behavioural serial memory that serves configuration image bytes to the loader.
`default_nettype none
module ecm_mem_model
   import ecm_pkg::*;
(
   input wire logic core_clk_in,
   input wire logic rst_b_in,
   input wire logic fetch_req_in,
   input wire logic [9:0] fetch_addr_in,
   input wire logic [3:0] delay_in,
   output logic fetch_valid_out,
   output logic [7:0] fetch_data_out
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [7:0] mem [1024];
   logic [4:0] gap_ff;
   // Serve the byte at the asked address, one per pulse.
   always_ff @(posedge core_clk_in or negedge rst_b_in)
   begin
      if (!rst_b_in)
      begin
         fetch_valid_out <= 1'b0;
         fetch_data_out <= 8'h00;
         gap_ff <= 5'h01;
      end
      else
      begin
         fetch_valid_out <= 1'b0;
         fetch_data_out <= ~fetch_data_out;
         gap_ff <= gap_ff - 5'h01;
         if (!fetch_req_in)
            gap_ff <= 5'h01;
         else if (gap_ff == 5'h00)
         begin
            fetch_valid_out <= 1'b1;
            fetch_data_out <= mem[fetch_addr_in];
            gap_ff <= {1'b0, delay_in} + 5'h02;
         end
      end
   end
endmodule
`default_nettype wire

/* tb/ecm_loader_tb_top.sv */
// Self-checking bench of the configuration image loader.
`default_nettype none
`define CHK(nm, ex, gt) \
   begin \
      n_checks++; \
      if ((gt) !== (ex)) \
      begin \
         failures++; \
         $display("ERROR %s expected %h seen %h", nm, ex, gt); \
      end \
   end
module ecm_loader_tb_top
   import ecm_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk, rst_b, rd, wr, wt, permit, done_b, freq, fvalid;
   logic [8:0] adr;
   logic [31:0] wd, rdat, q;
   logic [3:0] be, dly;
   logic [9:0] faddr;
   logic [7:0] fdata;
   ecm_cfg_t cfg;
   ecm_hdr_t hdr;
   int failures, n_checks, fidx, fbase;
   always #20 clk = ~clk;
   ecm_loader dut (.core_clk_in(clk), .rst_b_in(rst_b), .avs_address_in(adr),
      .avs_read_in(rd), .avs_write_in(wr), .avs_writedata_in(wd), .avs_byteenable_in(be),
      .avs_readdata_out(rdat), .avs_waitrequest_out(wt), .chain_load_permit_in(permit),
      .load_done_b_out(done_b), .fetch_req_out(freq), .fetch_addr_out(faddr),
      .fetch_valid_in(fvalid), .fetch_data_in(fdata), .cfg_out(cfg), .hdr_out(hdr));
   ecm_mem_model u_mem (.core_clk_in(clk), .rst_b_in(rst_b), .fetch_req_in(freq),
      .fetch_addr_in(faddr), .delay_in(dly), .fetch_valid_out(fvalid), .fetch_data_out(fdata));
   // Header first, then the block at the slot base.
   always @(posedge clk)
   begin
      if (fvalid && freq)
      begin
         `CHK("fetch_addr", (fidx < 3) ? 10'(fidx) : 10'(fbase + fidx - 3), faddr)
         fidx++;
      end
   end
   function automatic logic [7:0] crc_of(int base);
      logic [7:0] c;
      c = 8'h00;
      for (int i = 0; i < 40; i++)
      begin
         c = c ^ ((i < 3) ? u_mem.mem[i] : u_mem.mem[base + i - 3]);
         for (int k = 0; k < 8; k++)
            c = c[7] ? ((c << 1) ^ 8'h07) : (c << 1);
      end
      return c;
   endfunction
   task automatic end_sim();
      $display("checks %0d failures %0d", n_checks, failures);
      if (failures == 0 && n_checks > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask
   task automatic bus(input logic w, input logic [6:0] idx, input logic [31:0] d,
      input logic [3:0] e);
      int t;
      t = 0;
      @(posedge clk);
      adr <= {idx, 2'b00};
      rd <= !w;
      wr <= w;
      wd <= d;
      be <= e;
      do
      begin
         @(posedge clk);
         t++;
      end
      while (wt !== 1'b0 && t < 20);
      q = rdat;
      rd <= 1'b0;
      wr <= 1'b0;
      if (t >= 20)
         failures++;
   endtask
   task automatic wait_done(input logic ex);
      int t;
      t = 0;
      while (done_b !== ex && t < 2000)
      begin
         @(posedge clk);
         t++;
      end
      `CHK("load_done_b", ex, done_b)
   endtask
   // Lay out one block at its base with its CRC behind it.
   task automatic fill(input int base, input logic [7:0] b0, input logic [7:0] s, input logic bad);
      for (int k = 0; k < 37; k++)
         u_mem.mem[base + k] = s ^ 8'(k * 29);
      u_mem.mem[0] = b0;
      u_mem.mem[1] = 8'hff;
      u_mem.mem[2] = s;
      u_mem.mem[base + 2] = u_mem.mem[base + 2] & 8'h07;
      u_mem.mem[base + 9] = {u_mem.mem[base + 9][7:4], 4'he};
      u_mem.mem[base + 11] = u_mem.mem[base + 11] & 8'h0f;
      u_mem.mem[base + 37] = crc_of(base) ^ {7'h00, bad};
   endtask
   task automatic chk_cfg(input int base);
      logic [7:0] b [3:14];
      for (int i = 3; i < 15; i++)
         b[i] = u_mem.mem[base + i - 3];
      `CHK("ctl_01", b[3], cfg.ctl_01)
      `CHK("ctl_02", {2'b00, b[4][7:4], 1'b0, b[4][3]}, cfg.ctl_02)
      `CHK("ctl_04", {b[4][2:0], 5'h00}, cfg.ctl_04)
      `CHK("ctl_0f_10", {b[8], b[9]}, {cfg.ctl_0f, cfg.ctl_10})
      `CHK("ctl_11", {5'h00, b[10][7:5]}, cfg.ctl_11)
      `CHK("ctl_12", {b[10][4], 3'h0, b[10][3:0]}, cfg.ctl_12)
      `CHK("ctl_15", {2'b00, b[11][7:4], 2'b00}, cfg.ctl_15)
      `CHK("ctl_16", {b[11][3:0], b[12][7:4]}, cfg.ctl_16)
      `CHK("ctl_17", {4'he, b[13][7:4]}, cfg.ctl_17)
      `CHK("ctl_18_19", {5'h00, b[13][3:1], b[13][0], 7'h00}, {cfg.ctl_18, cfg.ctl_19})
   endtask
   task automatic t_reset();
      repeat (20) @(posedge clk);
      `CHK("hdr_reset", 15'h0000, hdr)
      `CHK("ctl_0f_reset", 8'h2f, cfg.ctl_0f)
      `CHK("fetch_req_held", 1'b0, freq)
      `CHK("done_reset", 1'b1, done_b)
   endtask
   task automatic t_load_good();
      fill(3, 8'ha3, 8'h5c, 1'b0);
      fidx = 0;
      fbase = 3;
      permit <= 1'b0;
      wait_done(1'b0);
      chk_cfg(3);
      `CHK("hdr", {1'b1, 1'b0, 1'b1, 4'h3, 8'h5c}, hdr)
      bus(1'b0, REG_HEADER, 32'h0, 4'hf);
      `CHK("header_reg", 32'h00005ca3, q)
      bus(1'b0, REG_STATUS, 32'h0, 4'hf);
      `CHK("status_good", 4'b1001, q[3:0])
      `CHK("req_after", 1'b0, freq)
   endtask
   task automatic t_load_bad();
      dly <= 4'h3;
      bus(1'b1, REG_CONTROL, 32'h00000001, 4'h1);
      fill(41, 8'hd2, 8'h93, 1'b1);
      fidx = 0;
      fbase = 41;
      bus(1'b1, REG_CONTROL, 32'h00000101, 4'h3);
      wait_done(1'b1);
      wait_done(1'b0);
      chk_cfg(41);
      `CHK("hdr2", {1'b1, 1'b1, 1'b0, 4'h2, 8'h93}, hdr)
      bus(1'b0, REG_STATUS, 32'h0, 4'hf);
      `CHK("status_bad", 4'b1101, q[3:0])
   endtask
   task automatic t_load_nocrc();
      fill(3, 8'h31, 8'h0a, 1'b1);
      fidx = 0;
      fbase = 3;
      bus(1'b1, REG_CONTROL, 32'h00000100, 4'h3);
      wait_done(1'b1);
      wait_done(1'b0);
      chk_cfg(3);
      `CHK("hdr3", {1'b0, 1'b0, 1'b1, 4'h1, 8'h0a}, hdr)
      bus(1'b0, REG_STATUS, 32'h0, 4'hf);
      `CHK("status_nocrc", 4'b0001, q[3:0])
   endtask
   task automatic t_regs();
      bus(1'b1, 7'h12, 32'hffffffa5, 4'hf);
      bus(1'b0, 7'h12, 32'h0, 4'hf);
      `CHK("ctl_12_rd", 32'h000000a5, q)
      `CHK("ctl_12_out", 8'ha5, cfg.ctl_12)
      bus(1'b1, 7'h30, 32'h000000ff, 4'hf);
      bus(1'b0, 7'h30, 32'h0, 4'hf);
      `CHK("unmapped", 32'h00000000, q)
   endtask
   initial
   begin
      clk = 1'b0;
      rst_b = 1'b0;
      {rd, wr, adr, wd, be, dly} = '0;
      permit = 1'b1;
      failures = 0;
      n_checks = 0;
      repeat (8) @(posedge clk);
      rst_b <= 1'b1;
      t_reset();
      t_load_good();
      t_load_bad();
      t_load_nocrc();
      t_regs();
      end_sim();
   end
   initial
   begin
      #(40 * 20000);
      failures++;
      end_sim();
   end
endmodule
`default_nettype wire
